// >>> bench/ccr_analog_model.sv
/*
 * Behavioural analog comparator that faces the control block.
 * Assumes levels in supply/96 units from the bench and from the ladder.
 */
`timescale 1ns/1ps
`default_nettype none
module ccr_analog_model
    import ccr_pkg::*;
(
    input  wire logic [LVL_W-1:0] pos_level,
    input  wire logic [LVL_W-1:0] neg_level,
    input  wire logic [LVL_W-1:0] ref_level,
    input  wire logic             ref_sel,
    output logic                  raw_compare
);
    // The reference replaces the negative pin when the mode asks; a tie reads low.
    assign raw_compare = pos_level > (ref_sel ? ref_level : neg_level);
endmodule
`default_nettype wire

// >>> bench/comparator_reference_control_tb.sv
/*
 * Self-checking bench for the comparator and reference control block.
 * Assumes the package constants and a zero-wait-state APB slave.
 */
`timescale 1ns/1ps
`default_nettype none
module comparator_reference_control_tb
    import ccr_pkg::*;
;
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, sleep_active = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, raw, pin2, oe, flag, valid, wake, e;
    logic [PIN_N-1:0] pin_level = '0, pdir, amask;
    logic [LVL_W-1:0] lvl, pos = 7'h0A, neg = 7'h32;
    ccr_analog_s actrl;
    int err_total = 0, comparisons = 0, cyc = 0;
    logic [5:0] mask_tab [8] = '{6'h07, 6'h03, 6'h03, 6'h01, 6'h03, 6'h01, 6'h03, 6'h00};
    // Free-running 50 MHz clock.
    always #10 clock = ~clock;
    ccr_control #(.SETTLE_NS(200)) dut_u (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .raw_compare(raw), .pin_level(pin_level),
        .sleep_active(sleep_active), .general_pin_two(pin2), .pin_two_oe(oe),
        .pin_direction_register(pdir), .analog_pin_mask(amask), .analog_ctrl(actrl),
        .internal_reference_voltage(lvl), .comparator_event_flag(flag),
        .result_valid(valid), .wake_request(wake));
    ccr_analog_model cmp_u (.pos_level(pos), .neg_level(neg), .ref_level(lvl),
        .ref_sel(actrl.reference_to_input), .raw_compare(raw));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic t_reset();
        pin_level <= 6'h3F;
        wt(3);
        apb(0, ADR_CMP, 0); chk(q, 0);
        apb(0, ADR_REF, 0); chk(q, 0);
        apb(0, ADR_DIR, 0); chk(q, 32'h3F);
        chk(pdir, 32'h3F);
        apb(0, ADR_PORT, 0); chk(q, 32'h38);
        $display("reset test done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            apb(1, ADR_CMP, m); apb(0, ADR_CMP, 0); chk(q[2:0], m);
            chk(valid, m == 0);
            wt(2); chk(amask, mask_tab[m]);
            chk(actrl.comparator_on, m > 0 && m < 7);
        end
        $display("mode test done");
    endtask
    task automatic t_result();
        pos <= 7'h3C;
        apb(1, ADR_CMP, 32'h57); wt(15);
        apb(0, ADR_CMP, 0); chk(q, 32'h17);
        pos <= 7'h28; wt(5);
        apb(0, ADR_CMP, 0); chk(q, 32'h57);
        $display("result test done");
    endtask
    task automatic t_ref();
        apb(1, ADR_REF, 32'hA5); wt(2); chk(lvl, 7'h14);
        apb(1, ADR_REF, 32'h83); wt(2); chk(lvl, 7'h21);
        apb(0, ADR_REF, 0); chk(q, 32'h83);
        apb(1, ADR_REF, 32'h03); wt(2); chk(lvl, 0);
        $display("reference test done");
    endtask
    task automatic t_pin();
        apb(1, ADR_DIR, 32'h3B); apb(1, ADR_CMP, 32'h01); wt(15);
        chk(valid, 1);
        chk(pdir, 32'h3B);
        pos <= 7'h3C; @(negedge clock); chk({oe, pin2}, 2'h3);
        @(posedge clock); pos <= 7'h28; @(negedge clock); chk(pin2, 0);
        apb(1, ADR_DIR, 32'h3F); wt(2); chk(oe, 0);
        $display("pin test done");
    endtask
    task automatic t_flag();
        sleep_active <= 1;
        apb(0, ADR_CMP, 0); apb(1, ADR_FLAG, 0); wt(2); chk(flag, 0);
        pos <= 7'h3C; wt(6); chk({flag, wake}, 2'h3);
        apb(0, ADR_CMP, 0); apb(1, ADR_FLAG, 0); wt(5); chk(flag, 0);
        apb(1, ADR_FLAG, 32'h08); wt(2); chk(flag, 1);
        sleep_active <= 0; wt(2);
        apb(0, ADR_CMP, 0); chk(q, 32'h41);
        apb(0, 12'h3FC, 0); chk(e, 1); chk(q, 0);
        $display("flag test done");
    endtask
    // Cycle ceiling against a hang.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        wt(10);
        reset_n <= 1;
        t_reset();
        t_modes();
        t_result();
        t_ref();
        t_pin();
        t_flag();
        test_done();
    end
endmodule
`default_nettype wire

// >>> logic/ccr_control.sv
/*
 * Control and status logic around one analog comparator and its internal
 * reference: APB register file, polarity, modes, pin routing, change flag,
 * settling window and sleep wake request.
 * Assumes an external analog comparator whose raw output is high when the
 * positive input exceeds the negative one, and a single 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ccr_control
    import ccr_pkg::*;
#(
    parameter int unsigned SETTLE_NS = 10000
)(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              raw_compare,
    input  wire logic [PIN_N-1:0]  pin_level,
    input  wire logic              sleep_active,
    output logic                   general_pin_two,
    output logic                   pin_two_oe,
    output logic      [PIN_N-1:0]  pin_direction_register,
    output logic      [PIN_N-1:0]  analog_pin_mask,
    output ccr_analog_s            analog_ctrl,
    output logic      [LVL_W-1:0]  internal_reference_voltage,
    output logic                   comparator_event_flag,
    output logic                   result_valid,
    output logic                   wake_request
);
    localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W      = $clog2(SETTLE_CYC + 1);

    // The settling check below watches eight cycles, so shorter windows are refused.
    if (SETTLE_CYC < 8 || SETTLE_CYC > 65535) begin : g_bad_settle
        $error("settling time out of range");
    end

    // Control register state.
    logic [MODE_W-1:0] comparator_mode_field;
    logic              polarity_invert;
    logic              input_switch;
    logic              reference_power_on;
    logic              reference_range_select;
    logic [TAP_W-1:0]  reference_tap_code;

    // Synchronisers, change detection and settling.
    logic              raw_meta;
    logic              raw_sync;
    logic [PIN_N-1:0]  pin_meta;
    logic [PIN_N-1:0]  pin_sync;
    logic              comparator_result;
    logic              seen_result;
    logic              mismatch;
    logic [CNT_W-1:0]  settle_count;

    // Bus decode.
    logic              setup;
    logic              access;
    logic              hit;
    logic              wr_cmp;
    logic              wr_ref;
    logic              wr_dir;
    logic              wr_flag;
    logic              cmp_touch;
    logic [31:0]       next_prdata;
    logic              next_flag;

    assign setup     = psel && !penable;
    assign access    = psel && penable && pready;
    assign hit       = (paddr == ADR_PORT) || (paddr == ADR_FLAG) || (paddr == ADR_CMP)
                    || (paddr == ADR_DIR) || (paddr == ADR_REF);
    assign wr_cmp    = access && pwrite && (paddr == ADR_CMP);
    assign wr_ref    = access && pwrite && (paddr == ADR_REF);
    assign wr_dir    = access && pwrite && (paddr == ADR_DIR);
    assign wr_flag   = access && pwrite && (paddr == ADR_FLAG);
    assign cmp_touch = access && (paddr == ADR_CMP);

    // The raw comparator output is asynchronous, so it is synchronised first.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            raw_meta <= 1'b0;
            raw_sync <= 1'b0;
        end else begin
            raw_meta <= raw_compare;
            raw_sync <= raw_meta;
        end
    end

    // Pin levels come from outside the clock domain as well.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_level;
            pin_sync <= pin_meta;
        end
    end

    // The raw input is high when positive exceeds negative; invert on request.
    assign comparator_result = raw_sync ^ polarity_invert;

    // The pin path skips the synchroniser on purpose, so it follows the
    // analog output with no clock latency; glitches near the threshold pass.
    always_comb begin
        general_pin_two = (raw_compare ^ polarity_invert) && ccr_out_mode(comparator_mode_field);
    end

    // Comparator control: the result bit has no storage, so writes cannot
    // reach it. Sleep and wake never touch these bits.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            comparator_mode_field <= MODE_RESET;
            polarity_invert       <= 1'b0;
            input_switch          <= 1'b0;
        end else if (wr_cmp) begin
            comparator_mode_field <= pwdata[MODE_W-1:0];
            polarity_invert       <= pwdata[CMP_INV_BIT];
            input_switch          <= pwdata[CMP_CIS_BIT];
        end
    end

    // Reference control.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reference_power_on     <= 1'b0;
            reference_range_select <= 1'b0;
            reference_tap_code     <= '0;
        end else if (wr_ref) begin
            reference_power_on     <= pwdata[REF_ON_BIT];
            reference_range_select <= pwdata[REF_RANGE_BIT];
            reference_tap_code     <= pwdata[TAP_W-1:0];
        end
    end

    // Pin direction register; a one makes the pin an input.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_direction_register <= DIR_RESET;
        end else if (wr_dir) begin
            pin_direction_register <= pwdata[PIN_N-1:0];
        end
    end

    // Analog controls are registered so the pads see clean levels. Sleep is
    // deliberately not an input here: enabled parts stay on through it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            analog_ctrl     <= '0;
            analog_pin_mask <= '0;
            pin_two_oe      <= 1'b0;
        end else begin
            analog_ctrl.comparator_on <= (comparator_mode_field != MODE_RESET)
                                      && (comparator_mode_field != MODE_OFF);
            analog_ctrl.reference_power_on     <= reference_power_on;
            analog_ctrl.reference_to_input     <= ccr_ref_mode(comparator_mode_field);
            analog_ctrl.input_switch           <= input_switch;
            analog_ctrl.reference_range_select <= reference_range_select;
            analog_ctrl.reference_tap_code     <= reference_tap_code;
            analog_pin_mask <= ccr_analog_mask(comparator_mode_field);
            pin_two_oe <= ccr_out_mode(comparator_mode_field) && !pin_direction_register[PIN_TWO];
        end
    end

    // Settling window restarts on every write that changes the mode.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            settle_count <= '0;
            result_valid <= 1'b0;
        end else if (wr_cmp && (pwdata[MODE_W-1:0] != comparator_mode_field)) begin
            settle_count <= CNT_W'(SETTLE_CYC);
            result_valid <= 1'b0;
        end else if (settle_count != '0) begin
            settle_count <= settle_count - 1'b1;
            result_valid <= 1'b0;
        end else begin
            result_valid <= 1'b1;
        end
    end

    // Last value seen by software; any comparator control access, read or write, re-arms it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seen_result <= 1'b0;
        end else if (cmp_touch) begin
            seen_result <= comparator_result;
        end
    end

    assign mismatch = (comparator_result != seen_result);

    // Mismatch keeps setting the flag, and a set beats a software clear.
    // Changes inside the settling window are held off; a result still differing when it ends sets the flag.
    always_comb begin
        next_flag = comparator_event_flag;
        if (wr_flag) begin
            next_flag = pwdata[FLAG_BIT];
        end
        if (mismatch && (settle_count == '0) && !cmp_touch) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            comparator_event_flag <= 1'b0;
        end else begin
            comparator_event_flag <= next_flag;
        end
    end

    // Wake request while asleep with the comparator running and an event up.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= sleep_active && analog_ctrl.comparator_on && next_flag;
        end
    end

    // Read data is formed in the setup cycle, so every access completes with no wait state.
    always_comb begin
        next_prdata = '0;
        if (paddr == ADR_CMP) begin
            next_prdata[CMP_RES_BIT]  = comparator_result;
            next_prdata[CMP_INV_BIT]  = polarity_invert;
            next_prdata[CMP_CIS_BIT]  = input_switch;
            next_prdata[MODE_W-1:0]   = comparator_mode_field;
        end else if (paddr == ADR_REF) begin
            next_prdata[REF_ON_BIT]    = reference_power_on;
            next_prdata[REF_RANGE_BIT] = reference_range_select;
            next_prdata[TAP_W-1:0]     = reference_tap_code;
        end else if (paddr == ADR_DIR) begin
            next_prdata[PIN_N-1:0] = pin_direction_register;
        end else if (paddr == ADR_FLAG) begin
            next_prdata[FLAG_BIT] = comparator_event_flag;
        end else if (paddr == ADR_PORT) begin
            next_prdata[PIN_N-1:0] = pin_sync & ~analog_pin_mask;
        end
    end

    // APB answer: ready one cycle after setup, error on unmapped addresses.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    ccr_ref_ladder u_ladder (
        .clock     (clock),
        .reset_n   (reset_n),
        .power_on  (reference_power_on),
        .range_low (reference_range_select),
        .tap       (reference_tap_code),
        .level     (internal_reference_voltage)
    );

    // Named steps for the settling and access checks.
    sequence s_mode_change;
        wr_cmp && (pwdata[MODE_W-1:0] != comparator_mode_field);
    endsequence

    sequence s_cmp_read;
        setup && !pwrite && (paddr == ADR_CMP);
    endsequence

    a_polarity_flip: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(polarity_invert) && $stable(raw_sync) |-> comparator_result != $past(comparator_result))
        else $error("invert change did not flip result");

    a_mode_written: assert property (@(posedge clock) disable iff (!reset_n)
        wr_cmp |=> comparator_mode_field == $past(pwdata[MODE_W-1:0]))
        else $error("mode field not written");

    a_result_readback: assert property (@(posedge clock) disable iff (!reset_n)
        s_cmp_read |=> prdata[CMP_RES_BIT] == $past(comparator_result))
        else $error("result bit not read back");

    a_pin_enable: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 pin_two_oe == ($past(ccr_out_mode(comparator_mode_field)) && !$past(pin_direction_register[PIN_TWO])))
        else $error("pin two enable wrong");

    a_port_analog: assert property (@(posedge clock) disable iff (!reset_n)
        setup && !pwrite && (paddr == ADR_PORT) |=> (prdata[PIN_N-1:0] & $past(analog_pin_mask)) == '0)
        else $error("analog pin read nonzero");

    a_reference_route: assert property (@(posedge clock) disable iff (!reset_n)
        wr_cmp ##1 1'b1 |=> analog_ctrl.reference_to_input == ccr_ref_mode($past(pwdata[MODE_W-1:0], 2)))
        else $error("reference routing wrong");

    a_settle_hold: assert property (@(posedge clock) disable iff (!reset_n)
        s_mode_change |=> !result_valid [*8])
        else $error("result valid during settling");

    a_flag_set: assert property (@(posedge clock) disable iff (!reset_n)
        mismatch && (settle_count == '0) && !cmp_touch |=> comparator_event_flag)
        else $error("mismatch did not set flag");

    a_mismatch_end: assert property (@(posedge clock) disable iff (!reset_n)
        cmp_touch |=> seen_result == $past(comparator_result))
        else $error("access did not end mismatch");

    a_reset_defaults: assert property (@(posedge clock)
        $rose(reset_n) |-> (comparator_mode_field == MODE_RESET) && !reference_power_on && !analog_ctrl.comparator_on)
        else $error("reset defaults wrong");

    a_sleep_wake: assert property (@(posedge clock) disable iff (!reset_n)
        sleep_active && analog_ctrl.comparator_on |=> wake_request == comparator_event_flag)
        else $error("no wake on comparator event");
endmodule
`default_nettype wire

// >>> logic/ccr_pkg.sv
/*
 * Shared constants, field layout, analog control bundle and mode decoding
 * for the comparator and reference control block.
 * Assumes a 50 MHz core clock and an APB register bus with 32-bit data.
 */
`default_nettype none
package ccr_pkg;
    // Core clock period in ns.
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned ADDR_W = 12;
    // Register indices; the byte address is four times the index.
    localparam logic [ADDR_W-1:0] IDX_PORT = 12'h005;
    localparam logic [ADDR_W-1:0] IDX_FLAG = 12'h00C;
    localparam logic [ADDR_W-1:0] IDX_CMP  = 12'h019;
    localparam logic [ADDR_W-1:0] IDX_DIR  = 12'h085;
    localparam logic [ADDR_W-1:0] IDX_REF  = 12'h099;
    localparam logic [ADDR_W-1:0] ADR_PORT = {IDX_PORT[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADR_FLAG = {IDX_FLAG[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADR_CMP  = {IDX_CMP[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADR_DIR  = {IDX_DIR[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADR_REF  = {IDX_REF[ADDR_W-3:0], 2'h0};
    // Field positions.
    localparam int unsigned CMP_RES_BIT   = 6;
    localparam int unsigned CMP_INV_BIT   = 4;
    localparam int unsigned CMP_CIS_BIT   = 3;
    localparam int unsigned MODE_W        = 3;
    localparam int unsigned REF_ON_BIT    = 7;
    localparam int unsigned REF_RANGE_BIT = 5;
    localparam int unsigned TAP_W         = 4;
    localparam int unsigned FLAG_BIT      = 3;
    localparam int unsigned PIN_N         = 6;
    localparam int unsigned PIN_TWO       = 2;
    localparam int unsigned LVL_W         = 7;
    // Reset values and special mode codes.
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
    localparam logic [MODE_W-1:0] MODE_OFF   = 3'h7;
    localparam logic [PIN_N-1:0]  DIR_RESET  = 6'h3F;
    // Reference ladder in units of supply/96, the common base of /24 and /32.
    localparam int unsigned LAD_DEN   = 96;
    localparam int unsigned LOW_DIV   = 24;
    localparam int unsigned HIGH_DIV  = 32;
    localparam int unsigned QUART_DIV = 4;

    typedef struct packed {
        logic             comparator_on;
        logic             reference_power_on;
        logic             reference_to_input;
        logic             input_switch;
        logic             reference_range_select;
        logic [TAP_W-1:0] reference_tap_code;
    } ccr_analog_s;

    // Modes that drive the result out on general pin two.
    function automatic logic ccr_out_mode(input logic [MODE_W-1:0] m);
        return (m == 3'h1) || (m == 3'h3) || (m == 3'h5);
    endfunction

    // Modes that route the internal reference to the negative input.
    function automatic logic ccr_ref_mode(input logic [MODE_W-1:0] m);
        return (m == 3'h3) || (m == 3'h4) || (m == 3'h5) || (m == 3'h6);
    endfunction

    // Pins that the mode claims as analog inputs.
    function automatic logic [PIN_N-1:0] ccr_analog_mask(input logic [MODE_W-1:0] m);
        case (m)
            3'h0:    return 6'h07;
            3'h1:    return 6'h03;
            3'h2:    return 6'h03;
            3'h3:    return 6'h01;
            3'h4:    return 6'h03;
            3'h5:    return 6'h01;
            3'h6:    return 6'h03;
            default: return 6'h00;
        endcase
    endfunction
endpackage
`default_nettype wire

// >>> logic/ccr_ref_ladder.sv
/*
 * Digital image of the reference ladder: the selected level in units of
 * supply/96, held at zero while the reference is powered down.
 * Assumes its controls come from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ccr_ref_ladder
    import ccr_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             power_on,
    input  wire logic             range_low,
    input  wire logic [TAP_W-1:0] tap,
    output logic      [LVL_W-1:0] level
);
    localparam logic [LVL_W-1:0] LOW_STEP  = LVL_W'(LAD_DEN / LOW_DIV);
    localparam logic [LVL_W-1:0] HIGH_STEP = LVL_W'(LAD_DEN / HIGH_DIV);
    localparam logic [LVL_W-1:0] HIGH_BASE = LVL_W'(LAD_DEN / QUART_DIV);

    logic [LVL_W-1:0] next_level;

    // Low range is tap/24, high range is 1/4 plus tap/32, both of supply.
    always_comb begin
        next_level = '0;
        if (power_on && range_low) begin
            next_level = LVL_W'(tap * LOW_STEP);
        end else if (power_on) begin
            next_level = LVL_W'(HIGH_BASE + tap * HIGH_STEP);
        end
    end

    // Powered down reads as zero so nothing downstream sees a stale level.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
    end

    a_ladder_level: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 level == ($past(power_on) ? ($past(range_low) ? $past(tap) * 4 : 24 + $past(tap) * 3) : 0))
        else $error("reference level does not match range and tap");
endmodule
`default_nettype wire
